// ### hw/scsi_regs_pkg.sv
// Package with register map, field layout and reset values of the SCSI register port
// Notes on behaviour
// RL1 - Three count bytes form 24-bit DMA count
// RL2 - Sixteen nine-bit FIFO entries at one address
// RL3 - Command packet sits in FIFO after phase
// RL4 - Command register holds two pending commands
// RL5 - Bit 7 flags DMA, low seven code
// RL6 - Shared address picks register by direction
// RL7 - Status low bits show bus phase lines
// RL8 - Terminal count set when counter hits zero
// RL9 - Parity error set only with checking enabled
// RL10 - Gross error never raises an interrupt
// RL11 - Status bit 7 shows interrupt request
// RL12 - Software writes destination ID, low bits
// RL13 - Target selection sets flag by attention level
// RL14 - Reselection as initiator sets reselected flag
// RL15 - Target command end sets function complete
// RL16 - Bus service set while initiator asserts attention
// RL17 - Reserved or mode-group command sets illegal flag
// RL18 - Software writes selection timeout value
// RL19 - Step counter advances; offset-max bit reads clear
// RL20 - Five-bit period sets minimum handshake spacing
// RL21 - FIFO flags: count low, step high
// RL22 - Software writes A start offset last
package scsi_regs_pkg;

  // ****************************************
  // Register byte addresses
  // ****************************************
  localparam logic [15:0] XFER_COUNT_LOW_ADDR = 16'hF0A4;
  localparam logic [15:0] XFER_COUNT_MID_ADDR = 16'hF0A5;
  localparam logic [15:0] FIFO_PORT_ADDR = 16'hF0A6;
  localparam logic [15:0] COMMAND_QUEUE_ADDR = 16'hF0A7;
  localparam logic [15:0] BUS_STATUS_DEST_ID_ADDR = 16'hF0AC;
  localparam logic [15:0] IRQ_CAUSE_TIMEOUT_ADDR = 16'hF0AD;
  localparam logic [15:0] STEP_COUNT_SYNC_PERIOD_ADDR = 16'hF0AE;
  localparam logic [15:0] FIFO_LEVEL_SYNC_OFFSET_ADDR = 16'hF0AF;
  localparam logic [15:0] CONFIG_ONE_ADDR = 16'hF0B4;
  localparam logic [15:0] CONFIG_TWO_ADDR = 16'hF0B7;
  localparam logic [15:0] CONFIG_THREE_ADDR = 16'hF0BC;
  localparam logic [15:0] CONFIG_FOUR_ADDR = 16'hF0BD;
  localparam logic [15:0] XFER_COUNT_HIGH_ADDR = 16'hF0BE;

  // ****************************************
  // Fields
  // ****************************************
  localparam int DMA_FLAG_BIT = 7;
  localparam int PARITY_CHECK_BIT = 4;
  localparam int FIFO_DEPTH = 16;
  localparam int FIFO_WIDTH = 9;
  localparam int CMD_DEPTH = 2;

  // Command codes of the mode groups and reserved ranges
  localparam logic [6:0] CMD_GROUP_MASK = 7'h70;
  localparam logic [6:0] CMD_GROUP_MODE_INIT = 7'h10;
  localparam logic [6:0] CMD_GROUP_MODE_TARG = 7'h20;
  localparam logic [6:0] CMD_GROUP_MODE_IDLE = 7'h40;
  localparam logic [6:0] CMD_RESERVED_LOW = 7'h04;
  localparam logic [6:0] CMD_RESERVED_HIGH = 7'h0F;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [7:0] CONFIG_RESET = 8'h00;
  localparam logic [23:0] COUNT_RESET = 24'h000000;
  localparam logic [7:0] TIMEOUT_RESET = 8'h00;

  typedef enum logic [1:0] {
    BUS_IDLE = 2'b00,
    BUS_WAIT = 2'b01,
    BUS_DONE = 2'b10
  } bus_state_t;

endpackage

// ### hw/scsi_controller_register_port.sv
// SCSI controller register port behind an APB slave
`timescale 1ns/1ps
`default_nettype none
module scsi_controller_register_port #(
  parameter int FIFO_DEPTH = scsi_regs_pkg::FIFO_DEPTH
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [15:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Bus phase lines, status events and link data
  input wire logic [2:0] bus_phase,
  input wire logic count_dec,
  input wire logic parity_error_event,
  input wire logic gross_error_event,
  input wire logic sel_event,
  input wire logic atn_level,
  input wire logic reselected_flag_event,
  input wire logic target_cmd_done,
  input wire logic step_advance,
  input wire logic step_clear,
  input wire logic sync_offset_at_max,
  input wire logic link_push,
  input wire logic [8:0] link_wdata,
  input wire logic link_pop,
  input wire logic cmd_take,
  output logic [8:0] link_rdata,
  output logic fifo_full,
  output logic fifo_empty,
  output logic cmd_valid,
  output logic dma_command_flag,
  output logic [6:0] cmd_code,
  output logic [23:0] xfer_count,
  output logic [2:0] destination_id,
  output logic [7:0] selection_timeout_value,
  output logic [4:0] sync_period_value,
  output logic [7:0] sync_offset_value,
  output logic irq
);

  localparam int PW = $clog2(FIFO_DEPTH);

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    scsi_regs_pkg::bus_state_t bst;
    logic [31:0] rdata;
    logic err;
    logic [23:0] count;
    logic [FIFO_DEPTH-1:0][8:0] fifo;
    logic [PW-1:0] rp;
    logic [PW-1:0] wp;
    logic [PW:0] level;
    logic [1:0][7:0] cmdq;
    logic [1:0] cmd_n;
    logic tc;
    logic pe;
    logic ge;
    logic [7:0] cause;
    logic [2:0] step;
    logic [2:0] dest;
    logic [7:0] tmo;
    logic [4:0] period;
    logic [7:0] offs;
    logic [3:0][7:0] cfg;
    logic [8:0] link_rd;
    // Decoded copies kept in flops so every output leaves a register
    logic rdy;
    logic full;
    logic empty;
    logic cmdv;
    logic irq_f;
  } state_t;

  state_t s_q, s_d;

  logic wr_acc;
  logic rd_acc;
  logic fifo_wr_sw;
  logic fifo_rd_sw;
  logic push;
  logic pop;
  logic illegal_command_flag;
  logic [6:0] wcode;
  logic [7:0] stat;
  logic [7:0] rval;
  logic hit;

  always_comb begin
    s_d = s_q;
    wr_acc = psel && !penable && pwrite && s_q.bst == scsi_regs_pkg::BUS_IDLE;
    rd_acc = psel && !penable && !pwrite && s_q.bst == scsi_regs_pkg::BUS_IDLE;
    wcode = pwdata[6:0];
    fifo_wr_sw = wr_acc && paddr == scsi_regs_pkg::FIFO_PORT_ADDR;
    fifo_rd_sw = rd_acc && paddr == scsi_regs_pkg::FIFO_PORT_ADDR;
    // Software access has priority; a link access in the same cycle is dropped
    push = (fifo_wr_sw || (link_push && !fifo_rd_sw)) && s_q.level != FIFO_DEPTH[PW:0]; // RL2 RL3
    pop = (fifo_rd_sw || (link_pop && !fifo_wr_sw)) && s_q.level != '0; // RL2
    illegal_command_flag = (wcode >= scsi_regs_pkg::CMD_RESERVED_LOW && wcode <= scsi_regs_pkg::CMD_RESERVED_HIGH)
      || (wcode & scsi_regs_pkg::CMD_GROUP_MASK) == scsi_regs_pkg::CMD_GROUP_MODE_INIT
      || (wcode & scsi_regs_pkg::CMD_GROUP_MASK) == scsi_regs_pkg::CMD_GROUP_MODE_TARG
      || (wcode & scsi_regs_pkg::CMD_GROUP_MASK) == scsi_regs_pkg::CMD_GROUP_MODE_IDLE;
    // Gross error is left out of the interrupt term
    stat = {s_q.cause != 8'h00, s_q.ge, s_q.pe, s_q.tc, 1'b0, bus_phase}; // RL7 RL10 RL11
    hit = 1'b1;
    case (paddr)
      scsi_regs_pkg::XFER_COUNT_LOW_ADDR: rval = s_q.count[7:0];
      scsi_regs_pkg::XFER_COUNT_MID_ADDR: rval = s_q.count[15:8];
      scsi_regs_pkg::XFER_COUNT_HIGH_ADDR: rval = s_q.count[23:16];
      scsi_regs_pkg::FIFO_PORT_ADDR: rval = s_q.fifo[s_q.rp][7:0];
      scsi_regs_pkg::COMMAND_QUEUE_ADDR: rval = s_q.cmdq[0];
      scsi_regs_pkg::BUS_STATUS_DEST_ID_ADDR: rval = stat; // RL6
      scsi_regs_pkg::IRQ_CAUSE_TIMEOUT_ADDR: rval = s_q.cause; // RL6
      scsi_regs_pkg::STEP_COUNT_SYNC_PERIOD_ADDR: rval = {4'h0, sync_offset_at_max ? 1'b0 : 1'b1, s_q.step}; // RL19
      scsi_regs_pkg::FIFO_LEVEL_SYNC_OFFSET_ADDR: rval = {s_q.step, 5'(s_q.level)}; // RL21
      scsi_regs_pkg::CONFIG_ONE_ADDR: rval = s_q.cfg[0];
      scsi_regs_pkg::CONFIG_TWO_ADDR: rval = s_q.cfg[1];
      scsi_regs_pkg::CONFIG_THREE_ADDR: rval = s_q.cfg[2];
      scsi_regs_pkg::CONFIG_FOUR_ADDR: rval = s_q.cfg[3];
      default: begin
        rval = 8'h00;
        hit = 1'b0;
      end
    endcase

    // ****************************************
    // APB slave: answer one cycle after setup
    // ****************************************
    case (s_q.bst)
      scsi_regs_pkg::BUS_IDLE: begin
        if (psel && !penable) begin
          s_d.bst = scsi_regs_pkg::BUS_DONE;
          s_d.rdata = {24'h000000, pwrite ? 8'h00 : rval};
          s_d.err = !hit;
        end
      end
      scsi_regs_pkg::BUS_DONE: begin
        s_d.bst = scsi_regs_pkg::BUS_IDLE;
        s_d.rdata = 32'h00000000;
        s_d.err = 1'b0;
      end
      default: s_d.bst = scsi_regs_pkg::BUS_IDLE;
    endcase

    // ****************************************
    // Transfer counter
    // ****************************************
    if (count_dec && s_q.count != '0) begin
      s_d.count = s_q.count - 24'd1;
      if (s_q.count == 24'd1) begin
        s_d.tc = 1'b1; // RL8
      end
    end
    if (wr_acc) begin
      case (paddr)
        scsi_regs_pkg::XFER_COUNT_LOW_ADDR: s_d.count[7:0] = pwdata[7:0]; // RL1
        scsi_regs_pkg::XFER_COUNT_MID_ADDR: s_d.count[15:8] = pwdata[7:0]; // RL1
        scsi_regs_pkg::XFER_COUNT_HIGH_ADDR: s_d.count[23:16] = pwdata[7:0]; // RL1
        scsi_regs_pkg::BUS_STATUS_DEST_ID_ADDR: s_d.dest = pwdata[2:0]; // RL6 RL12
        scsi_regs_pkg::IRQ_CAUSE_TIMEOUT_ADDR: s_d.tmo = pwdata[7:0]; // RL6 RL18
        scsi_regs_pkg::STEP_COUNT_SYNC_PERIOD_ADDR: s_d.period = pwdata[4:0]; // RL20
        scsi_regs_pkg::FIFO_LEVEL_SYNC_OFFSET_ADDR: s_d.offs = pwdata[7:0];
        scsi_regs_pkg::CONFIG_ONE_ADDR: s_d.cfg[0] = pwdata[7:0];
        scsi_regs_pkg::CONFIG_TWO_ADDR: s_d.cfg[1] = pwdata[7:0];
        scsi_regs_pkg::CONFIG_THREE_ADDR: s_d.cfg[2] = pwdata[7:0];
        scsi_regs_pkg::CONFIG_FOUR_ADDR: s_d.cfg[3] = pwdata[7:0];
        default: ;
      endcase
    end

    // ****************************************
    // FIFO, nine bits per entry
    // ****************************************
    if (push) begin
      s_d.fifo[s_q.wp] = fifo_wr_sw ? {1'b0, pwdata[7:0]} : link_wdata;
      s_d.wp = s_q.wp + 1'b1;
    end
    if (pop) begin
      s_d.link_rd = s_q.fifo[s_q.rp];
      s_d.rp = s_q.rp + 1'b1;
    end
    s_d.level = s_q.level + (PW+1)'(push) - (PW+1)'(pop);

    // ****************************************
    // Two-deep command queue
    // ****************************************
    if (cmd_take && s_q.cmd_n != 2'd0) begin
      s_d.cmdq[0] = s_q.cmdq[1]; // RL4
      s_d.cmd_n = s_q.cmd_n - 2'd1;
    end
    if (wr_acc && paddr == scsi_regs_pkg::COMMAND_QUEUE_ADDR) begin
      if (illegal_command_flag) begin
        s_d.cause[6] = 1'b1; // RL17
      end else if (s_d.cmd_n != 2'd2) begin
        s_d.cmdq[s_d.cmd_n[0]] = pwdata[7:0]; // RL4 RL5
        s_d.cmd_n = s_d.cmd_n + 2'd1;
      end
    end

    // ****************************************
    // Sequence step
    // ****************************************
    // Step events beat a clear-on-read in the same cycle
    if (step_clear) begin
      s_d.step = 3'd0;
    end else if (step_advance) begin
      s_d.step = s_q.step + 3'd1; // RL19
    end else if (rd_acc && paddr == scsi_regs_pkg::IRQ_CAUSE_TIMEOUT_ADDR) begin
      s_d.step = 3'd0;
    end

    // ****************************************
    // Status and causes: reading clears, events win
    // ****************************************
    if (rd_acc && paddr == scsi_regs_pkg::IRQ_CAUSE_TIMEOUT_ADDR) begin
      s_d.cause = 8'h00;
      s_d.tc = 1'b0;
      s_d.pe = 1'b0;
      s_d.ge = 1'b0;
    end
    if (count_dec && s_q.count == 24'd1) s_d.tc = 1'b1; // RL8
    if (parity_error_event && s_q.cfg[0][scsi_regs_pkg::PARITY_CHECK_BIT]) s_d.pe = 1'b1; // RL9
    if (gross_error_event) s_d.ge = 1'b1; // RL10
    if (sel_event && !atn_level) s_d.cause[0] = 1'b1; // RL13
    if (sel_event && atn_level) s_d.cause[1] = 1'b1; // RL13
    if (reselected_flag_event) s_d.cause[2] = 1'b1; // RL14
    if (target_cmd_done) s_d.cause[3] = 1'b1; // RL15
    if (atn_level) s_d.cause[4] = 1'b1; // RL16
    if (wr_acc && paddr == scsi_regs_pkg::COMMAND_QUEUE_ADDR && illegal_command_flag) s_d.cause[6] = 1'b1; // RL17
    s_d.rdy = s_d.bst == scsi_regs_pkg::BUS_DONE;
    s_d.full = s_d.level == FIFO_DEPTH[PW:0];
    s_d.empty = s_d.level == '0;
    s_d.cmdv = s_d.cmd_n != 2'd0;
    s_d.irq_f = s_d.cause != 8'h00; // RL11
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= '0;
      s_q.empty <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  // ****************************************
  // Outputs straight from state flops
  // ****************************************
  assign prdata = s_q.rdata;
  assign pready = s_q.rdy;
  assign pslverr = s_q.err;
  assign link_rdata = s_q.link_rd;
  assign fifo_full = s_q.full;
  assign fifo_empty = s_q.empty;
  assign cmd_valid = s_q.cmdv;
  assign dma_command_flag = s_q.cmdq[0][scsi_regs_pkg::DMA_FLAG_BIT]; // RL5
  assign cmd_code = s_q.cmdq[0][6:0];
  assign xfer_count = s_q.count;
  assign destination_id = s_q.dest;
  assign selection_timeout_value = s_q.tmo;
  assign sync_period_value = s_q.period;
  assign sync_offset_value = s_q.offs;
  assign irq = s_q.irq_f; // RL11

endmodule
`default_nettype wire

// ### verif/scsi_far_side.sv
// Behavioural SCSI far side: phase lines, event pulses and link FIFO traffic
`timescale 1ns/1ps
`default_nettype none
module scsi_far_side (
  input wire logic pclk,
  output logic [2:0] bus_phase,
  output logic atn_level,
  output logic sync_offset_max_flag,
  output logic [10:0] ev,
  output logic [8:0] link_wdata
);
  initial begin
    bus_phase = 3'h0;
    atn_level = 1'b0;
    sync_offset_max_flag = 1'b0;
    ev = 11'h000;
    link_wdata = 9'h1FF;
  end
  task automatic lines(input logic [2:0] ph, input logic atn, input logic mx);
    @(posedge pclk);
    bus_phase <= ph;
    atn_level <= atn;
    sync_offset_max_flag <= mx;
  endtask
  task automatic fire(input logic [10:0] m);
    @(posedge pclk);
    ev <= m;
    @(posedge pclk);
    ev <= 11'h000;
  endtask
  // Bytes enter the FIFO while the command phase still shows
  task automatic send_cmd(input int n, input logic [7:0] b);
    for (int i = 0; i < n; i++) begin
      @(posedge pclk);
      ev[8] <= 1'b1;
      link_wdata <= {1'b0, b + 8'(i)};
    end
    @(posedge pclk);
    ev[8] <= 1'b0;
    link_wdata <= 9'h1FF;
  endtask
endmodule
`default_nettype wire

// ### verif/scsi_port_sva.sv
// Assertions on the register port pins
`timescale 1ns/1ps
`default_nettype none
module scsi_port_sva (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [15:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [2:0] bus_phase,
  input wire logic count_dec,
  input wire logic [23:0] xfer_count,
  input wire logic [2:0] destination_id,
  input wire logic [7:0] selection_timeout_value,
  input wire logic [4:0] sync_period_value,
  input wire logic fifo_full,
  input wire logic fifo_empty,
  input wire logic irq
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence rd_s(logic [15:0] a);
    psel && !penable && !pwrite && paddr == a;
  endsequence
  sequence wr_s(logic [15:0] a);
    psel && !penable && pwrite && paddr == a;
  endsequence
  apb_answer_a: assert property (psel && !penable |=> pready)
    else $error("no answer after setup");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  err_ready_a: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  phase_read_a: assert property (rd_s(scsi_regs_pkg::BUS_STATUS_DEST_ID_ADDR)
    |=> prdata[2:0] == $past(bus_phase)) else $error("phase bits wrong");
  irq_read_a: assert property (rd_s(scsi_regs_pkg::BUS_STATUS_DEST_ID_ADDR)
    |=> prdata[7] == $past(irq)) else $error("status bit 7 wrong");
  count_low_a: assert property (wr_s(scsi_regs_pkg::XFER_COUNT_LOW_ADDR)
    |=> xfer_count[7:0] == $past(pwdata[7:0])) else $error("count low byte");
  count_dec_a: assert property (count_dec && xfer_count != 0 && !psel
    |=> xfer_count == $past(xfer_count) - 24'h000001) else $error("count step");
  dest_id_a: assert property (wr_s(scsi_regs_pkg::BUS_STATUS_DEST_ID_ADDR)
    |=> destination_id == $past(pwdata[2:0])) else $error("destination id");
  timeout_a: assert property (wr_s(scsi_regs_pkg::IRQ_CAUSE_TIMEOUT_ADDR)
    |=> selection_timeout_value == $past(pwdata[7:0])) else $error("timeout");
  period_a: assert property (wr_s(scsi_regs_pkg::STEP_COUNT_SYNC_PERIOD_ADDR)
    |=> sync_period_value == $past(pwdata[4:0])) else $error("period");
  fifo_flags_a: assert property (!(fifo_full && fifo_empty))
    else $error("fifo full and empty");
endmodule
bind scsi_controller_register_port scsi_port_sva u_sva (.pclk, .presetn, .psel,
  .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .bus_phase,
  .count_dec, .xfer_count, .destination_id, .selection_timeout_value,
  .sync_period_value, .fifo_full, .fifo_empty, .irq);
`default_nettype wire

// ### verif/scsi_controller_register_port_tb.sv
// Self-checking bench for the SCSI register port
`timescale 1ns/1ps
`default_nettype none
module scsi_controller_register_port_tb;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, atn_level, sync_offset_max_flag, irq;
  logic fifo_full, fifo_empty, cmd_valid, dma_command_flag;
  logic [15:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [2:0] bus_phase, destination_id;
  logic [10:0] ev;
  logic [8:0] link_wdata, link_rdata;
  logic [6:0] cmd_code;
  logic [23:0] xfer_count;
  logic [7:0] selection_timeout_value, sync_offset_value;
  logic [4:0] sync_period_value;
  int fail_count = 0;
  int checks = 0;
  scsi_far_side far (.pclk, .bus_phase, .atn_level, .sync_offset_max_flag, .ev, .link_wdata);
  scsi_controller_register_port #(.FIFO_DEPTH(16)) u_dut (.pclk, .presetn, .psel,
    .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .bus_phase,
    .count_dec(ev[0]), .parity_error_event(ev[1]), .gross_error_event(ev[2]),
    .sel_event(ev[3]), .atn_level, .reselected_flag_event(ev[4]), .target_cmd_done(ev[5]),
    .step_advance(ev[6]), .step_clear(ev[7]), .sync_offset_at_max(sync_offset_max_flag),
    .link_push(ev[8]), .link_wdata, .link_pop(ev[9]), .cmd_take(ev[10]), .link_rdata,
    .fifo_full, .fifo_empty, .cmd_valid, .dma_command_flag, .cmd_code, .xfer_count,
    .destination_id, .selection_timeout_value, .sync_period_value,
    .sync_offset_value, .irq);
  // ****************************************
  // Bus tasks and scenarios
  // ****************************************
  task automatic give_verdict();
    if (fail_count == 0 && checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
    checks++;
    if (got !== ex) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", nm, ex, got);
    end
  endtask
  // Waits on pready itself; only the watchdog bounds a hung slave
  task automatic apb(input logic w, input logic [15:0] a, input logic [7:0] d,
                     output logic [31:0] q, output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    logic [31:0] q;
    logic e;
    apb(1'b1, a, d, q, e);
  endtask
  task automatic rdc(input logic [15:0] a, input logic [7:0] m, input logic [7:0] ex);
    logic [31:0] q;
    logic e;
    apb(1'b0, a, 8'h00, q, e);
    chk("read data", {24'h0, ex}, q & {24'h0, m});
  endtask
  task automatic t_regs();
    logic [15:0] cfg [4] = '{16'hF0B4, 16'hF0B7, 16'hF0BC, 16'hF0BD};
    logic [31:0] q;
    logic e;
    foreach (cfg[i]) rdc(cfg[i], 8'hFF, scsi_regs_pkg::CONFIG_RESET);
    foreach (cfg[i]) wr(cfg[i], 8'hA0 + 8'(i));
    foreach (cfg[i]) rdc(cfg[i], 8'hFF, 8'hA0 + 8'(i));
    apb(1'b0, 16'hF0A8, 8'h00, q, e);
    chk("pslverr", 32'h1, {31'h0, e});
    wr(16'hF0AC, 8'h05);
    wr(16'hF0AD, 8'h9C);
    wr(16'hF0AE, 8'h1B);
    wr(16'hF0AF, 8'h33);
    chk("destination_id", 32'h5, {29'h0, destination_id});
    chk("timeout", 32'h9C, {24'h0, selection_timeout_value});
    chk("period", 32'h1B, {27'h0, sync_period_value});
    chk("offset", 32'h33, {24'h0, sync_offset_value});
  endtask
  task automatic t_status();
    for (int p = 0; p < 8; p++) begin
      far.lines(3'(p), 1'b0, 1'b0);
      rdc(16'hF0AC, 8'h07, 8'(p));
    end
    wr(16'hF0B4, 8'h00);
    rdc(16'hF0AD, 8'h00, 8'h00);
    far.fire(11'h002);
    rdc(16'hF0AC, 8'h20, 8'h00);
    wr(16'hF0B4, 8'h10);
    far.fire(11'h002);
    rdc(16'hF0AC, 8'h20, 8'h20);
    far.fire(11'h004);
    rdc(16'hF0AC, 8'hC0, 8'h40);
    chk("irq", 32'h0, {31'h0, irq});
    far.fire(11'h008);
    rdc(16'hF0AC, 8'h80, 8'h80);
    chk("irq", 32'h1, {31'h0, irq});
  endtask
  task automatic t_causes();
    logic [10:0] evs [4] = '{11'h008, 11'h008, 11'h010, 11'h020};
    logic [7:0] want [4] = '{8'h01, 8'h12, 8'h04, 8'h08};
    rdc(16'hF0AD, 8'h00, 8'h00);
    for (int i = 0; i < 4; i++) begin
      far.lines(3'h0, i == 1, 1'b0);
      far.fire(evs[i]);
      far.lines(3'h0, 1'b0, 1'b0);
      rdc(16'hF0AD, 8'h1F, want[i]);
    end
  endtask
  task automatic t_count();
    wr(16'hF0A4, 8'h02);
    wr(16'hF0A5, 8'h01);
    wr(16'hF0BE, 8'hC3);
    chk("xfer_count", 32'hC30102, {8'h0, xfer_count});
    rdc(16'hF0A5, 8'hFF, 8'h01);
    wr(16'hF0A5, 8'h00);
    wr(16'hF0BE, 8'h00);
    rdc(16'hF0AD, 8'h00, 8'h00);
    far.fire(11'h001);
    rdc(16'hF0AC, 8'h10, 8'h00);
    far.fire(11'h001);
    rdc(16'hF0AC, 8'h10, 8'h10);
    chk("xfer_count", 32'h0, {8'h0, xfer_count});
  endtask
  task automatic t_fifo();
    rdc(16'hF0AD, 8'h00, 8'h00);
    for (int i = 0; i < 3; i++) far.fire(11'h040);
    rdc(16'hF0AE, 8'h0F, 8'h0B);
    far.lines(3'h0, 1'b0, 1'b1);
    rdc(16'hF0AE, 8'h08, 8'h00);
    for (int i = 0; i < 17; i++) wr(16'hF0A6, 8'h30 + 8'(i));
    chk("fifo_full", 32'h1, {31'h0, fifo_full});
    rdc(16'hF0AF, 8'hFF, 8'h70);
    far.fire(11'h200);
    #1;
    chk("link_rdata", 32'h30, {23'h0, link_rdata});
    for (int i = 1; i < 16; i++) rdc(16'hF0A6, 8'hFF, 8'h30 + 8'(i));
    chk("fifo_empty", 32'h1, {31'h0, fifo_empty});
    far.fire(11'h080);
    rdc(16'hF0AF, 8'hFF, 8'h00);
    far.lines(3'h2, 1'b0, 1'b0);
    far.send_cmd(6, 8'h12);
    far.lines(3'h3, 1'b0, 1'b0);
    for (int i = 0; i < 6; i++) rdc(16'hF0A6, 8'hFF, 8'h12 + 8'(i));
  endtask
  task automatic t_cmd();
    logic [7:0] bad [5] = '{8'h04, 8'h0F, 8'h10, 8'h20, 8'h40};
    wr(16'hF0A7, 8'h81);
    wr(16'hF0A7, 8'h02);
    wr(16'hF0A7, 8'h03);
    chk("cmd head", 32'h181, {23'h0, cmd_valid, dma_command_flag, cmd_code});
    far.fire(11'h400);
    #1;
    chk("cmd next", 32'h102, {23'h0, cmd_valid, dma_command_flag, cmd_code});
    far.fire(11'h400);
    #1;
    chk("cmd empty", 32'h0, {31'h0, cmd_valid});
    foreach (bad[i]) begin
      wr(16'hF0A7, bad[i]);
      rdc(16'hF0AD, 8'h40, 8'h40);
    end
    chk("cmd empty", 32'h0, {31'h0, cmd_valid});
  endtask
  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 16'h0000;
    pwdata = 32'h0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_status();
    t_causes();
    t_count();
    t_fifo();
    t_cmd();
    give_verdict();
  end
  // Whole run is about a hundred transfers; this is about a hundred times that
  initial begin
    #2000000;
    fail_count++;
    give_verdict();
  end
endmodule
`default_nettype wire
